/* verilog/ftl_pkg.sv */
`default_nettype none
// ============================================================
// Fan thermal limit bank: shared constants and types
package ftl_pkg;
  localparam int NUM_CH = 3;

  // Register indices as printed; byte address is four times the index
  localparam logic [9:0] IDX_MIN_DUTY1   = 10'h064;
  localparam logic [9:0] IDX_MIN_DUTY2   = 10'h065;
  localparam logic [9:0] IDX_MIN_DUTY3   = 10'h066;
  localparam logic [9:0] IDX_START_R1    = 10'h067;
  localparam logic [9:0] IDX_START_LOC   = 10'h068;
  localparam logic [9:0] IDX_START_R2    = 10'h069;
  localparam logic [9:0] IDX_CRIT_R1     = 10'h06a;
  localparam logic [9:0] IDX_CRIT_LOC    = 10'h06b;
  localparam logic [9:0] IDX_CRIT_R2     = 10'h06c;
  localparam logic [9:0] IDX_HYST_R1_LOC = 10'h06d;
  localparam logic [9:0] IDX_HYST_R2     = 10'h06e;
  localparam logic [9:0] IDX_TEST_CTRL   = 10'h06f;
  localparam logic [9:0] IDX_OFFSET_R1   = 10'h070;
  localparam logic [9:0] IDX_OFFSET_LOC  = 10'h071;
  // Control, status, interrupt and duty readback registers
  localparam logic [9:0] IDX_CTRL        = 10'h080;
  localparam logic [9:0] IDX_STATUS      = 10'h081;
  localparam logic [9:0] IDX_INT_STAT    = 10'h082;
  localparam logic [9:0] IDX_INT_CLR     = 10'h083;
  localparam logic [9:0] IDX_INT_EN      = 10'h084;
  localparam logic [9:0] IDX_DUTY1       = 10'h085;

  // Reset values
  localparam logic [7:0] RST_MIN_DUTY    = 8'h80;
  localparam logic [7:0] RST_START       = 8'h5a;
  localparam logic [7:0] RST_CRIT        = 8'h64;
  localparam logic [7:0] RST_HYST_R1_LOC = 8'h44;
  localparam logic [7:0] RST_HYST_R2     = 8'h40;
  localparam logic [7:0] RST_TEST_CTRL   = 8'h00;
  localparam logic [7:0] RST_OFFSET      = 8'h00;
  localparam logic [7:0] RST_CTRL        = 8'h10;
  localparam logic [5:0] RST_INT         = 6'h00;

  // Control register fields
  localparam int CTRL_AUTO_BIT    = 0;
  localparam int CTRL_LOCK_BIT    = 1;
  localparam int CTRL_PIN_OUT_BIT = 2;
  localparam int CTRL_SPAN_LSB    = 3;
  // Hysteresis nibble positions
  localparam int HYST_R1_LSB  = 4;
  localparam int HYST_LOC_LSB = 0;
  localparam int HYST_R2_LSB  = 4;
  localparam int TEST_EN_BIT  = 0;

  // Duty and limit codes
  localparam logic [7:0] DUTY_OFF     = 8'h00;
  localparam logic [7:0] DUTY_FULL    = 8'hff;
  localparam logic [7:0] CRIT_DISABLE = 8'h80;
  localparam logic [3:0] SPAN_SHIFT   = 4'h5;   // 8 degrees at select 0

  // Readings in quarter degrees, two's complement
  typedef struct packed {
    logic [NUM_CH-1:0][9:0] reading;
  } ftl_temps_t;
  typedef struct packed {
    logic [NUM_CH-1:0][7:0] duty;
  } ftl_duty_t;
  typedef struct packed {
    logic out;
    logic oe;
  } ftl_od_t;
endpackage
`default_nettype wire

/* verilog/ftl_fan_limit_bank.sv */
// Function
// - A minimum duty code maps linearly to output duty, 0x00 off through 0xFF full.
// - Minimum duty writes are ignored while automatic fan control is on.
// - Above its start temperature a fan runs at minimum duty and ramps over the span.
// - Any channel above its critical limit forces every fan output to full duty.
// - A critical limit of 0x80 disables the forced full duty for that channel.
// - Forced full duty holds until the temperature falls below limit minus hysteresis.
// - With the pin set as output, a reading a quarter degree over a limit pulls it low; the code pulls it low only at half a degree over.
// - A fan keeps minimum duty below start until start minus hysteresis is reached.
// - Each channel has a four-bit hysteresis covering zero to fifteen degrees.
// - Once locked, start, limit, hysteresis, test and offset registers ignore writes.
// - Bit 0 of the test register enters parity tree test mode, clearing it leaves.
// - The signed remote 1 offset is added to its reading at a quarter degree per bit.
// - The signed local offset is added to its reading at a quarter degree per bit.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ftl_fan_limit_bank (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  // Temperature readings
  input  wire ftl_pkg::ftl_temps_t temps,
  // Fan duty outputs
  output var  ftl_pkg::ftl_duty_t  fanDuty,
  // Open-drain overtemperature pin, active low
  input  wire logic              overtempPinNIn,
  output var  ftl_pkg::ftl_od_t    overtempPinN,
  // Test mode and interrupt
  output var  logic              testMode,
  output var  logic              irq
);

  // All checks sample on the rising clock and sleep through reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ============================================================
  // Bus decode
  logic [9:0]  regIdx;
  logic        wrEn;
  logic        setupPh;
  logic [7:0]  wrByte;
  logic        lockQ;
  logic        autoMode;
  logic        known;
  logic [31:0] rdData;

  assign regIdx  = paddr[11:2];
  assign setupPh = psel & ~penable;
  assign wrEn    = psel & penable & pwrite & pready & (paddr[1:0] == 2'b00); // Drop misaligned
  assign wrByte  = pwdata[7:0];

  // ============================================================
  // Configuration storage
  logic [2:0][7:0] minDutyQ;
  logic [2:0][7:0] startQ;
  logic [2:0][7:0] critLimQ;
  logic [7:0]      hystR1LocQ;
  logic [7:0]      hystR2Q;
  logic [7:0]      testCtrlQ;
  logic [7:0]      offR1Q;
  logic [7:0]      offLocQ;
  logic [7:0]      ctrlQ;
  logic [5:0]      intStatQ;
  logic [5:0]      intEnQ;
  logic [1:0]      spanSel;
  logic            pinAsOut;

  assign lockQ    = ctrlQ[ftl_pkg::CTRL_LOCK_BIT];
  assign autoMode = ctrlQ[ftl_pkg::CTRL_AUTO_BIT];
  assign pinAsOut = ctrlQ[ftl_pkg::CTRL_PIN_OUT_BIT];
  assign spanSel  = ctrlQ[ftl_pkg::CTRL_SPAN_LSB +: 2];

  // Per-channel working signals
  logic [2:0][3:0]  hyst;
  logic [2:0][7:0]  offs;
  logic [2:0][11:0] tCorr;
  logic [2:0]       runQ;
  logic [2:0]       critQ;
  logic [2:0]       overPin;
  logic [2:0][7:0]  autoDuty;
  logic [2:0]       critSet;
  logic [2:0]       runSet;
  logic             anyCrit;

  // Hysteresis nibble selection per channel
  assign hyst[0] = hystR1LocQ[ftl_pkg::HYST_R1_LSB +: 4];
  assign hyst[1] = hystR1LocQ[ftl_pkg::HYST_LOC_LSB +: 4];
  assign hyst[2] = hystR2Q[ftl_pkg::HYST_R2_LSB +: 4];
  // Offsets per channel; remote 2 offset lives outside this bank
  assign offs[0] = offR1Q;
  assign offs[1] = offLocQ;
  assign offs[2] = 8'h00;
  assign anyCrit = |critQ;

  genvar i;
  generate
    for (i = 0; i < ftl_pkg::NUM_CH; i++) begin : g_ch
      logic [11:0] startQd;
      logic [11:0] critQd;
      logic [11:0] hystQd;
      logic [11:0] delta;
      logic [11:0] spanQd;
      logic [16:0] prod;
      logic [16:0] extra;
      logic        critOff;
      logic        wrMin;
      logic        wrStart;
      logic        wrCrit;

      // Offset correction, quarter degree per bit
      assign tCorr[i] = {{2{temps.reading[i][9]}}, temps.reading[i]}
                      + {{4{offs[i][7]}}, offs[i]};
      // Whole-degree limits scaled to quarter degrees
      assign startQd = {{2{startQ[i][7]}}, startQ[i], 2'b00};
      assign critQd  = {{2{critLimQ[i][7]}}, critLimQ[i], 2'b00};
      assign hystQd  = {6'h00, hyst[i], 2'b00};
      assign critOff = critLimQ[i] == ftl_pkg::CRIT_DISABLE;
      assign critSet[i] = ~critOff & ($signed(tCorr[i]) > $signed(critQd));
      assign runSet[i]  = $signed(tCorr[i]) > $signed(startQd);
      assign overPin[i] = ~critOff
                        & ($signed(tCorr[i]) > $signed(critQd + 12'h001));

      // Ramp from minimum duty to full over the span
      assign delta  = tCorr[i] - startQd;
      assign spanQd = 12'h020 << spanSel;
      assign prod   = 17'(ftl_pkg::DUTY_FULL - minDutyQ[i]) * {8'h00, delta[8:0]};
      assign extra  = prod >> (ftl_pkg::SPAN_SHIFT + {2'b00, spanSel});
      assign autoDuty[i] = ~runQ[i] ? ftl_pkg::DUTY_OFF
                         : ($signed(delta) <= $signed(12'h000)) ? minDutyQ[i]
                         : (delta >= spanQd) ? ftl_pkg::DUTY_FULL
                         : minDutyQ[i] + extra[7:0];

      assign wrMin   = wrEn & (regIdx == 10'(ftl_pkg::IDX_MIN_DUTY1 + i));
      assign wrStart = wrEn & (regIdx == 10'(ftl_pkg::IDX_START_R1 + i));
      assign wrCrit  = wrEn & (regIdx == 10'(ftl_pkg::IDX_CRIT_R1 + i));

      // Limit registers
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          minDutyQ[i] <= ftl_pkg::RST_MIN_DUTY;
          startQ[i]   <= ftl_pkg::RST_START;
          critLimQ[i] <= ftl_pkg::RST_CRIT;
        end else begin
          if (wrMin && !autoMode) minDutyQ[i] <= wrByte;
          if (wrStart && !lockQ) startQ[i] <= wrByte;
          if (wrCrit && !lockQ) critLimQ[i] <= wrByte;
        end
      end

      // Start hysteresis and critical hold state
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          runQ[i]  <= 1'b0;
          critQ[i] <= 1'b0;
        end else begin
          if (runSet[i]) runQ[i] <= 1'b1;
          else if ($signed(tCorr[i]) <= $signed(startQd - hystQd))
            runQ[i] <= 1'b0;
          if (critSet[i]) critQ[i] <= 1'b1;
          else if (critOff || $signed(tCorr[i]) < $signed(critQd - hystQd))
            critQ[i] <= 1'b0;
        end
      end

      // Fan output: forced, automatic or direct minimum duty
      always_ff @(posedge ref_clk) begin
        if (rst) fanDuty.duty[i] <= ftl_pkg::DUTY_OFF;
        else if (anyCrit) fanDuty.duty[i] <= ftl_pkg::DUTY_FULL;
        else if (autoMode) fanDuty.duty[i] <= autoDuty[i];
        else fanDuty.duty[i] <= minDutyQ[i];
      end

      // Checks per channel
      crit_disable_a: assert property (critOff |=> !critQ[i])
        else $error("critical hold active on disabled limit");
      crit_hold_a: assert property (
        critQ[i] && !critOff && $signed(tCorr[i]) >= $signed(critQd - hystQd)
        |=> critQ[i])
        else $error("critical hold released above limit minus hysteresis");
      hyst_keep_a: assert property (
        runQ[i] && $signed(tCorr[i]) > $signed(startQd - hystQd) |=> runQ[i])
        else $error("fan stopped above start minus hysteresis");
      start_run_a: assert property (
        runQ[i] && autoMode && !anyCrit
        |=> fanDuty.duty[i] >= $past(minDutyQ[i])
            && (fanDuty.duty[i] != 8'h00 || $past(minDutyQ[i]) == 8'h00))
        else $error("running fan below minimum duty");
      min_lock_a: assert property (wrMin && autoMode |=> $stable(minDutyQ[i]))
        else $error("minimum duty written in automatic mode");
      start_lock_a: assert property (wrStart && lockQ |=> $stable(startQ[i]))
        else $error("start temperature written while locked");
    end
  endgenerate

  // ============================================================
  // Shared registers and interrupt status
  logic       wrHyst1;
  logic       wrHyst2;
  logic       wrTest;
  logic       wrOffR1;
  logic       wrOffLoc;
  logic       wrCtrl;
  logic       wrIntClr;
  logic       wrIntEn;
  logic [5:0] intEvent;
  logic [5:0] intClr;

  assign wrHyst1  = wrEn & (regIdx == ftl_pkg::IDX_HYST_R1_LOC) & ~lockQ;
  assign wrHyst2  = wrEn & (regIdx == ftl_pkg::IDX_HYST_R2) & ~lockQ;
  assign wrTest   = wrEn & (regIdx == ftl_pkg::IDX_TEST_CTRL) & ~lockQ;
  assign wrOffR1  = wrEn & (regIdx == ftl_pkg::IDX_OFFSET_R1) & ~lockQ;
  assign wrOffLoc = wrEn & (regIdx == ftl_pkg::IDX_OFFSET_LOC) & ~lockQ;
  assign wrCtrl   = wrEn & (regIdx == ftl_pkg::IDX_CTRL);
  assign wrIntClr = wrEn & (regIdx == ftl_pkg::IDX_INT_CLR);
  assign wrIntEn  = wrEn & (regIdx == ftl_pkg::IDX_INT_EN);
  // Events: entry into critical hold, fan start
  assign intEvent = {runSet & ~runQ, critSet & ~critQ};
  assign intClr   = wrIntClr ? wrByte[5:0] : 6'h00;

  // Shared configuration registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hystR1LocQ <= ftl_pkg::RST_HYST_R1_LOC;
      hystR2Q    <= ftl_pkg::RST_HYST_R2;
      testCtrlQ  <= ftl_pkg::RST_TEST_CTRL;
      offR1Q     <= ftl_pkg::RST_OFFSET;
      offLocQ    <= ftl_pkg::RST_OFFSET;
    end else begin
      if (wrHyst1) hystR1LocQ <= wrByte;
      if (wrHyst2) hystR2Q <= wrByte;
      if (wrTest) testCtrlQ <= {7'h00, wrByte[ftl_pkg::TEST_EN_BIT]};
      if (wrOffR1) offR1Q <= wrByte;
      if (wrOffLoc) offLocQ <= wrByte;
    end
  end

  // Control register; lock is set-only until reset
  always_ff @(posedge ref_clk) begin
    if (rst) ctrlQ <= ftl_pkg::RST_CTRL;
    else if (wrCtrl) begin
      ctrlQ <= wrByte;
      ctrlQ[ftl_pkg::CTRL_LOCK_BIT] <= lockQ | wrByte[ftl_pkg::CTRL_LOCK_BIT];
    end
  end

  // Sticky status, enable mask and interrupt line; set wins over clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      intStatQ <= ftl_pkg::RST_INT;
      intEnQ   <= ftl_pkg::RST_INT;
      irq      <= 1'b0;
    end else begin
      intStatQ <= (intStatQ & ~intClr) | intEvent;
      if (wrIntEn) intEnQ <= wrByte[5:0];
      irq <= |(intStatQ & intEnQ);
    end
  end

  // ============================================================
  // Overtemperature pin and test mode outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      overtempPinN <= '0;
      testMode     <= 1'b0;
    end else begin
      overtempPinN.out <= 1'b0;
      overtempPinN.oe  <= pinAsOut & (|overPin);
      testMode         <= testCtrlQ[ftl_pkg::TEST_EN_BIT];
    end
  end

  // ============================================================
  // Read mux
  always_comb begin
    known  = paddr[1:0] == 2'b00;
    rdData = 32'h0000_0000;
    case (regIdx)
      ftl_pkg::IDX_MIN_DUTY1:   rdData[7:0] = minDutyQ[0];
      ftl_pkg::IDX_MIN_DUTY2:   rdData[7:0] = minDutyQ[1];
      ftl_pkg::IDX_MIN_DUTY3:   rdData[7:0] = minDutyQ[2];
      ftl_pkg::IDX_START_R1:    rdData[7:0] = startQ[0];
      ftl_pkg::IDX_START_LOC:   rdData[7:0] = startQ[1];
      ftl_pkg::IDX_START_R2:    rdData[7:0] = startQ[2];
      ftl_pkg::IDX_CRIT_R1:     rdData[7:0] = critLimQ[0];
      ftl_pkg::IDX_CRIT_LOC:    rdData[7:0] = critLimQ[1];
      ftl_pkg::IDX_CRIT_R2:     rdData[7:0] = critLimQ[2];
      ftl_pkg::IDX_HYST_R1_LOC: rdData[7:0] = hystR1LocQ;
      ftl_pkg::IDX_HYST_R2:     rdData[7:0] = hystR2Q;
      ftl_pkg::IDX_TEST_CTRL:   rdData[7:0] = testCtrlQ;
      ftl_pkg::IDX_OFFSET_R1:   rdData[7:0] = offR1Q;
      ftl_pkg::IDX_OFFSET_LOC:  rdData[7:0] = offLocQ;
      ftl_pkg::IDX_CTRL:        rdData[7:0] = ctrlQ;
      ftl_pkg::IDX_STATUS:      rdData[7:0] = {overtempPinNIn, |overPin, critQ, runQ};
      ftl_pkg::IDX_INT_STAT:    rdData[5:0] = intStatQ;
      ftl_pkg::IDX_INT_CLR:     rdData[7:0] = 8'h00;
      ftl_pkg::IDX_INT_EN:      rdData[5:0] = intEnQ;
      10'(ftl_pkg::IDX_DUTY1 + 0): rdData[7:0] = fanDuty.duty[0];
      10'(ftl_pkg::IDX_DUTY1 + 1): rdData[7:0] = fanDuty.duty[1];
      10'(ftl_pkg::IDX_DUTY1 + 2): rdData[7:0] = fanDuty.duty[2];
      default:                  known = 1'b0;
    endcase
  end

  // No wait states: answer registered at the setup edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setupPh;
      pslverr <= setupPh & ~known;
      prdata  <= (setupPh && !pwrite && known) ? rdData : 32'h0000_0000;
    end
  end

  // ============================================================
  // Checks on forced duty, pin, test mode, lock and interrupt

  duty_full_crit_a: assert property (anyCrit |=> fanDuty.duty == {3{8'hff}})
    else $error("fans not forced to full duty");
  pin_drive_a: assert property (pinAsOut && (|overPin) |=> overtempPinN.oe
    && !overtempPinN.out)
    else $error("overtemperature pin not pulled low");
  test_mode_a: assert property (wrTest |-> ##2 testMode == $past(pwdata[0], 2))
    else $error("test mode does not follow enable bit");
  hyst_lock_a: assert property (wrEn && lockQ && regIdx == ftl_pkg::IDX_HYST_R1_LOC
    |=> $stable(hystR1LocQ))
    else $error("hysteresis written while locked");
  irq_level_a: assert property ((intStatQ & intEnQ) != 6'h00 |=> irq)
    else $error("interrupt not raised for enabled status");
  manual_duty_a: assert property (!autoMode && !anyCrit
    |=> fanDuty.duty[0] == $past(minDutyQ[0]))
    else $error("manual duty differs from minimum duty code");

  // Bus answer, misaligned writes, sticky status and lock
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one access cycle");
  rd_idle_a: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("read data or error shown outside the access cycle");
  misalign_wr_a: assert property (psel && penable && pwrite && paddr[1:0] != 2'b00
    |=> $stable(startQ) && $stable(ctrlQ))
    else $error("misaligned write changed a register");
  status_sticky_a: assert property (intEvent != 6'h00
    |=> (intStatQ & $past(intEvent)) == $past(intEvent))
    else $error("status event lost against a clear");
  crit_entry_a: assert property ((|critSet) |=> anyCrit)
    else $error("critical entry did not start the hold");
  lock_keep_a: assert property (lockQ |=> lockQ)
    else $error("lock bit cleared without reset");
  offset_lock_a: assert property (wrEn && lockQ && regIdx == ftl_pkg::IDX_OFFSET_R1
    |=> $stable(offR1Q))
    else $error("offset written while locked");
  test_lock_a: assert property (wrEn && lockQ && regIdx == ftl_pkg::IDX_TEST_CTRL
    |=> $stable(testCtrlQ))
    else $error("test enable written while locked");

  crit_entry_c: cover property (!anyCrit ##1 anyCrit);
  lock_set_c:   cover property (!lockQ ##1 lockQ);
  fan_start_c:  cover property (autoMode && !runQ[0] ##1 runQ[0]);
  irq_rise_c:   cover property (!irq ##1 irq);

endmodule // ftl_fan_limit_bank
`default_nettype wire

/* tb/ftl_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Host side: APB master issuing register transfers
module ftl_host_model (
  // Clock
  input  wire logic        ref_clk,
  // APB master
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // One transfer: setup cycle, then access until pready is sampled high
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [1:0] lo,
                      input logic [7:0] d, output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, lo};
    // Unused upper bits of the test register are never written
    pwdata  <= {24'h00_0000, (idx == ftl_pkg::IDX_TEST_CTRL) ? {7'h00, d[0]} : d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // ftl_host_model
`default_nettype wire

/* tb/tb_ftl_fan_limit_bank.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench for the fan thermal limit bank
module tb_ftl_fan_limit_bank;
  logic                ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic                overtempPinNIn, testMode, irq, err, autoOn, locked;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rd;
  logic [7:0]          v;
  logic [7:0]          shadow [14];
  logic [9:0]          rds [6];
  ftl_pkg::ftl_temps_t temps;
  ftl_pkg::ftl_duty_t  fanDuty;
  ftl_pkg::ftl_od_t    overtempPinN;
  int                  mismatches, n_tests, cycles, seed, ch;

  // Pull-up on the open-drain pin
  assign overtempPinNIn = overtempPinN.oe ? 1'b0 : 1'b1;

  ftl_fan_limit_bank u_ftl_fan_limit_bank (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .temps(temps), .fanDuty(fanDuty),
    .overtempPinNIn(overtempPinNIn), .overtempPinN(overtempPinN), .testMode(testMode),
    .irq(irq));
  ftl_host_model u_ftl_host_model (.ref_clk(ref_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // Clock, 40 ns period
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Write, tracking which bank registers should accept it
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    u_ftl_host_model.xfer(1'b1, idx, 2'b00, d, rd, err);
    if (idx >= 10'h064 && idx <= 10'h071 && ((idx <= 10'h066) ? !autoOn : !locked))
      shadow[idx - 10'h064] = (idx == ftl_pkg::IDX_TEST_CTRL) ? {7'h00, d[0]} : d;
    if (idx == ftl_pkg::IDX_CTRL) begin
      autoOn = d[0];
      locked = locked | d[1];
    end
  endtask

  task automatic rdchk(input logic [9:0] idx, input logic [7:0] exp);
    u_ftl_host_model.xfer(1'b0, idx, 2'b00, 8'h00, rd, err);
    chk(rd, {24'h00_0000, exp});
  endtask

  task automatic bank_chk;
    for (int i = 0; i < 14; i++) rdchk(10'h064 + 10'(i), shadow[i]);
  endtask

  task automatic settle;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic temp(input int c, input logic [9:0] r);
    @(posedge ref_clk);
    temps.reading[c] <= r;
    settle();
  endtask

  // Expected auto duty for a running fan, delta and span in quarter degrees
  function automatic logic [7:0] auto_duty(input logic [7:0] mn, input int delta, input int span);
    if (delta <= 0) return mn;
    if (delta >= span) return 8'hff;
    return mn + 8'(((255 - int'(mn)) * delta) / span);
  endfunction

  // Main sequence
  initial begin
    rst = 1'b1;
    temps = '0;
    {autoOn, locked} = 2'b00;
    {mismatches, n_tests, cycles} = '0;
    seed = 32'h0000_a549;
    shadow = '{8'h80, 8'h80, 8'h80, 8'h5a, 8'h5a, 8'h5a, 8'h64, 8'h64, 8'h64, 8'h44,
               8'h40, 8'h00, 8'h00, 8'h00};
    rds = '{10'h169, 10'h178, 10'h188, 10'h168, 10'h159, 10'h158};
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    settle();
    chk(32'(fanDuty), 32'h0080_8080);
    bank_chk();
    // Unmapped and misaligned accesses
    u_ftl_host_model.xfer(1'b0, 10'h090, 2'b00, 8'h00, rd, err);
    chk(32'(err), 32'h0000_0001);
    u_ftl_host_model.xfer(1'b1, ftl_pkg::IDX_START_R1, 2'b01, 8'h11, rd, err);
    chk(32'(err), 32'h0000_0001);
    // Manual mode: corners then random codes
    for (int i = 0; i < 9; i++) begin
      ch = (i < 3) ? 0 : int'($unsigned($random(seed)) % 3);
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'h40 : (i == 2) ? 8'hff : 8'($random(seed));
      wr(10'h064 + 10'(ch), v);
      settle();
      chk(32'(fanDuty.duty[ch]), {24'h00_0000, v});
    end
    for (int c = 0; c < 3; c++) wr(10'h064 + 10'(c), 8'h40);
    // Auto mode, span of 32 quarter degrees
    wr(ftl_pkg::IDX_CTRL, 8'h01);
    wr(ftl_pkg::IDX_MIN_DUTY1, 8'h10);
    rdchk(ftl_pkg::IDX_MIN_DUTY1, 8'h40);
    chk(32'(fanDuty), 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      temp(1, rds[i]);
      v = (i < 5) ? auto_duty(8'h40, int'(rds[i]) - 360, 32) : 8'h00;
      chk(32'(fanDuty.duty[1]), {24'h00_0000, v});
    end
    // Critical limit on remote 1 with interrupt
    wr(ftl_pkg::IDX_INT_EN, 8'h01);
    temp(0, 10'h191);
    chk(32'(fanDuty), 32'h00ff_ffff);
    chk(32'(irq), 32'h0000_0001);
    rdchk(ftl_pkg::IDX_INT_STAT, 8'h19);
    temp(0, 10'h180);
    chk(32'(fanDuty.duty[2]), 32'h0000_00ff);
    temp(0, 10'h17f);
    chk(32'(fanDuty.duty[2]), 32'h0000_0000);
    wr(ftl_pkg::IDX_INT_EN, 8'h00);
    settle();
    chk(32'(irq), 32'h0000_0000);
    wr(ftl_pkg::IDX_INT_CLR, 8'h3f);
    wr(ftl_pkg::IDX_INT_EN, 8'h3f);
    settle();
    chk(32'(irq), 32'h0000_0000);
    rdchk(ftl_pkg::IDX_INT_STAT, 8'h00);
    temp(0, 10'h000);
    // Disabled limit on the local channel
    wr(ftl_pkg::IDX_CRIT_LOC, 8'h80);
    temp(1, 10'h1ff);
    chk(32'(fanDuty), 32'h0000_ff00);
    temp(1, 10'h000);
    // Overtemperature pin as output
    wr(ftl_pkg::IDX_CTRL, 8'h05);
    temp(2, 10'h191);
    chk(32'(overtempPinN), 32'h0000_0000);
    temp(2, 10'h192);
    chk(32'(overtempPinN), 32'h0000_0001);
    rdchk(ftl_pkg::IDX_STATUS, 8'h64);
    temp(2, 10'h000);
    // Reading offsets
    wr(ftl_pkg::IDX_OFFSET_R1, 8'h01);
    temp(0, 10'h168);
    chk(32'(fanDuty.duty[0]), 32'h0000_0045);
    rdchk(ftl_pkg::IDX_DUTY1, 8'h45);
    wr(ftl_pkg::IDX_OFFSET_LOC, 8'hff);
    temp(1, 10'h169);
    chk(32'(fanDuty.duty[1]), 32'h0000_0000);
    // Parity tree test mode
    wr(ftl_pkg::IDX_TEST_CTRL, 8'h01);
    settle();
    chk(32'(testMode), 32'h0000_0001);
    wr(ftl_pkg::IDX_TEST_CTRL, 8'h00);
    settle();
    chk(32'(testMode), 32'h0000_0000);
    // Full hysteresis, fifteen degrees on every channel
    wr(ftl_pkg::IDX_HYST_R1_LOC, 8'hff);
    wr(ftl_pkg::IDX_HYST_R2, 8'hf0);
    bank_chk();
    // Lock, then try to overwrite everything
    wr(ftl_pkg::IDX_CTRL, 8'h07);
    for (int i = 0; i < 14; i++) wr(10'h064 + 10'(i), ~shadow[i]);
    wr(ftl_pkg::IDX_CTRL, 8'h05);
    settle();
    chk(32'(testMode), 32'h0000_0000);
    bank_chk();
    final_report();
  end
endmodule // tb_ftl_fan_limit_bank
`default_nettype wire
